/* sim/asr_receiver_tb_top.sv */
// self-checking testbench of the asynchronous serial receiver
`timescale 1ns/1ps
module asr_receiver_tb_top;
	import asr_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock_in;
	logic        rst_in;
	logic        line;
	logic        rx_on;
	logic [12:0] baud;
	logic        m9, par_on, par_odd, wake_adr, idle_count_after_stop;
	logic        slp_wr, slp_val, st_rd, d_rd, n_rd;
	logic        en_full, en_idle, en_ovr, en_nf, en_fe, en_pf;
	logic        en_txe, en_txd, txe, txd, t9, tload;
	logic [7:0]  data;
	logic        r9, full, ovr, nf, fe, pf, idle, slp;
	logic        tx_irq, rx_irq, err_irq, t9_sh;
	int          n_mismatch;
	int          check_count;
	int          cycles;

	asr_serial_tx u_asr_serial_tx (.clock_in(clock_in), .line_out(line));

	asr_receiver u_asr_receiver (
		.clock_in(clock_in), .rst_in(rst_in),
		.serial_in_pin_in(line), .rx_on_in(rx_on),
		.baud_divisor_value_in(baud), .nine_bit_mode_in(m9),
		.parity_on_in(par_on), .parity_odd_select_in(par_odd),
		.wake_on_address_in(wake_adr), .idle_count_after_stop_in(idle_count_after_stop),
		.rx_sleep_write_in(slp_wr), .rx_sleep_value_in(slp_val),
		.status_read_in(st_rd), .data_read_in(d_rd),
		.ninth_read_in(n_rd), .rx_full_irq_enable_in(en_full),
		.idle_irq_enable_in(en_idle), .overrun_irq_enable_in(en_ovr),
		.noise_irq_enable_in(en_nf), .framing_irq_enable_in(en_fe),
		.parity_irq_enable_in(en_pf), .tx_empty_irq_enable_in(en_txe),
		.tx_done_irq_enable_in(en_txd), .tx_buffer_empty_flag_in(txe),
		.transmit_done_flag_in(txd), .tx_ninth_bit_in(t9),
		.tx_load_in(tload), .rx_data_out(data), .rx_ninth_bit_out(r9),
		.rx_buffer_full_flag_out(full), .overrun_flag_out(ovr),
		.noise_flag_out(nf), .framing_error_flag_out(fe),
		.parity_error_flag_out(pf), .idle_flag_out(idle),
		.rx_sleep_out(slp), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq),
		.err_irq_out(err_irq), .tx_shift_ninth_out(t9_sh)
	);

	// ----------------------------------------------------------------
	// clock and timeout
	// ----------------------------------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [8:0] e,
			input logic [8:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic clk(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	// status read, then data read, with ninth read only when nine is set
	task automatic clear_seq(input logic nine);
		clk(1);
		st_rd = 1'b1;
		clk(1);
		st_rd = 1'b0;
		d_rd = 1'b1;
		n_rd = nine;
		clk(1);
		d_rd = 1'b0;
		n_rd = 1'b0;
		clk(2);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{m9, par_on, par_odd, wake_adr, idle_count_after_stop, slp_wr, slp_val} = '0;
		{st_rd, d_rd, n_rd, en_idle, en_nf, en_fe, en_pf} = '0;
		{en_txd, txd, t9, tload, en_txe, txe} = '0;
		{en_full, en_ovr} = 2'b11;
		n_mismatch = 0;
		check_count = 0;
		cycles = 0;
		rx_on = 1'b1;
		baud = 13'h0001;
		rst_in = 1'b1;
		clk(3);
		rst_in = 1'b0;
		clk(8);
		chk("full after reset", 9'h000, {8'h00, full});
		u_asr_serial_tx.send(9'h055, 8, 1'b1, -1);
		clk(1);
		chk("data", 9'h055, {1'b0, data});
		chk("full", 9'h001, {8'h00, full});
		chk("noise", 9'h000, {8'h00, nf});
		chk("rx irq", 9'h001, {8'h00, rx_irq});
		$display("test receive done");
		u_asr_serial_tx.send(9'h00F, 8, 1'b1, 3);
		clk(1);
		chk("overrun", 9'h001, {8'h00, ovr});
		chk("kept data", 9'h055, {1'b0, data});
		chk("noise on overrun", 9'h000, {8'h00, nf});
		chk("err irq", 9'h001, {8'h00, err_irq});
		clear_seq(1'b0);
		chk("full cleared", 9'h000, {8'h00, full});
		chk("overrun cleared", 9'h000, {8'h00, ovr});
		$display("test overrun done");
		clk(40);
		u_asr_serial_tx.send(9'h000, 8, 1'b1, 3);
		clk(1);
		chk("noise", 9'h001, {8'h00, nf});
		chk("data noisy", 9'h000, {1'b0, data});
		clear_seq(1'b0);
		$display("test noise done");
		par_on = 1'b1;
		for (int s = 0; s < 2; s++) begin
			par_odd = s[0];
			clk(40);
			u_asr_serial_tx.send(9'h001, 8, 1'b1, -1);
			clk(1);
			chk("parity", {8'h00, ~s[0]}, {8'h00, pf});
			clear_seq(1'b0);
		end
		par_on = 1'b0;
		$display("test parity done");
		clk(40);
		u_asr_serial_tx.send(9'h081, 8, 1'b0, -1);
		clk(1);
		chk("framing", 9'h001, {8'h00, fe});
		clk(180);
		chk("held full", 9'h001, {8'h00, full});
		chk("held data", 9'h081, {1'b0, data});
		chk("no overrun", 9'h000, {8'h00, ovr});
		chk("idle", 9'h001, {8'h00, idle});
		clear_seq(1'b0);
		chk("framing cleared", 9'h000, {8'h00, fe});
		chk("idle cleared", 9'h000, {8'h00, idle});
		$display("test framing done");
		m9 = 1'b1;
		clk(40);
		u_asr_serial_tx.send(9'h1A5, 9, 1'b1, -1);
		clk(1);
		chk("nine data", 9'h1A5, {r9, data});
		clear_seq(1'b0);
		chk("full nine", 9'h001, {8'h00, full});
		clk(1);
		n_rd = 1'b1;
		clk(1);
		n_rd = 1'b0;
		clk(1);
		chk("full nine read", 9'h000, {8'h00, full});
		m9 = 1'b0;
		$display("test nine bit done");
		wake_adr = 1'b1;
		slp_wr = 1'b1;
		slp_val = 1'b1;
		clk(1);
		slp_wr = 1'b0;
		clk(40);
		u_asr_serial_tx.send(9'h012, 8, 1'b1, -1);
		clk(1);
		chk("asleep full", 9'h000, {8'h00, full});
		chk("asleep", 9'h001, {8'h00, slp});
		u_asr_serial_tx.send(9'h092, 8, 1'b1, -1);
		clk(1);
		chk("woken", 9'h000, {8'h00, slp});
		chk("mark data", 9'h092, {1'b0, data});
		clear_seq(1'b0);
		$display("test address wake done");
		wake_adr = 1'b0;
		slp_wr = 1'b1;
		clk(1);
		slp_wr = 1'b0;
		u_asr_serial_tx.send(9'h000, 8, 1'b1, -1);
		clk(100);
		chk("idle early", 9'h001, {8'h00, slp});
		clk(70);
		chk("idle wake", 9'h000, {8'h00, slp});
		chk("idle full", 9'h000, {8'h00, full});
		$display("test idle wake done");
		idle_count_after_stop = 1'b1;
		slp_wr = 1'b1;
		clk(1);
		slp_wr = 1'b0;
		u_asr_serial_tx.send(9'h0F0, 8, 1'b1, -1);
		clk(100);
		chk("stop idle early", 9'h001, {8'h00, slp});
		clk(70);
		chk("stop idle wake", 9'h000, {8'h00, slp});
		idle_count_after_stop = 1'b0;
		$display("test idle type done");
		rx_on = 1'b0;
		u_asr_serial_tx.send(9'h055, 8, 1'b1, -1);
		clk(1);
		chk("receiver off", 9'h000, {8'h00, full});
		rx_on = 1'b1;
		baud = 13'h0003;
		clk(20);
		baud = 13'h0000;
		clk(5);
		baud = 13'h0001;
		clk(40);
		u_asr_serial_tx.pulse_low(4);
		clk(170);
		chk("false start", 9'h000, {8'h00, full});
		$display("test receiver off and false start done");
		en_txe = 1'b1;
		txe = 1'b1;
		t9 = 1'b1;
		tload = 1'b1;
		clk(1);
		tload = 1'b0;
		clk(2);
		chk("tx irq", 9'h001, {8'h00, tx_irq});
		chk("tx ninth", 9'h001, {8'h00, t9_sh});
		txe = 1'b0;
		clk(3);
		chk("tx irq off", 9'h000, {8'h00, tx_irq});
		en_txd = 1'b1;
		txd = 1'b1;
		clk(2);
		chk("tx done irq", 9'h001, {8'h00, tx_irq});
		$display("test transmit request done");
		print_verdict();
	end
endmodule

/* sim/asr_serial_tx.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module asr_serial_tx (
	input  wire logic clock_in,
	output logic      line_out
);
	// ----------------------------------------------------------------
	// idle line
	// ----------------------------------------------------------------
	initial begin
		line_out = 1'b1;
	end

	// ----------------------------------------------------------------
	// one frame, sixteen clocks a bit at divisor one
	// ----------------------------------------------------------------
	// gl names a bit whose slot 9 sample is flipped, -1 for none
	task automatic send(input logic [8:0] d, input int n,
			input logic stp, input int gl);
		logic v;
		for (int b = 0; b < n + 2; b++) begin
			v = (b == 0) ? 1'b0 : (b <= n) ? d[b-1] : stp;
			for (int k = 0; k < 16; k++) begin
				@(negedge clock_in);
				line_out = v ^ ((b == gl) && (k == 8));
			end
		end
		@(negedge clock_in);
		line_out = 1'b1;
	endtask

	// ----------------------------------------------------------------
	// short low pulse, a false start
	// ----------------------------------------------------------------
	task automatic pulse_low(input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge clock_in);
			line_out = 1'b0;
		end
		@(negedge clock_in);
		line_out = 1'b1;
	endtask
endmodule

/* verilog/asr_baud_tick.sv */
// sixteen-times baud tick divider
`timescale 1ns/1ps
module asr_baud_tick #(
	parameter int DIV_W = asr_pkg::BAUD_DIV_W
) (
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic             enable_in,
	input  wire logic [DIV_W-1:0] divisor_in,
	output logic                  tick_out
);
	import asr_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} asr_baud_s;

	asr_baud_s q;
	asr_baud_s n;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (!enable_in || divisor_in == '0) begin
			n.cnt = '0;
		end else if (q.cnt >= DIV_W'(divisor_in - 1'b1)) begin
			n.cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tick_out = q.tick;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_steady3;
		enable_in && divisor_in == DIV_W'(3);
	endsequence

	property p_tick_period;
		@(posedge clock_in) disable iff (rst_in)
		(tick_out and s_steady3) ##1 s_steady3 [*2] |=> tick_out;
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("tick period wrong for divisor three");

	property p_zero_stops;
		@(posedge clock_in) disable iff (rst_in)
		divisor_in == '0 |=> !tick_out;
	endproperty
	a_zero_stops: assert property (p_zero_stops)
		else $error("tick with zero divisor");

endmodule

/* verilog/asr_pkg.sv */
// constants, types and state layout of the asynchronous serial receiver
// How it works
// - frame is low start, eight or nine data bits lsb first, high stop
// - completed character moves to an empty buffer and sets the full flag
// - character completing into a full buffer sets overrun and is dropped
// - input sampled at sixteen ticks per bit, slots numbered 1 to 16
// - falling edge is a low sample after three consecutive high samples
// - slots 3, 5, 7 checked; start accepted when two or more read low
// - each bit decided by majority of slots 8, 9 and 10
// - verified start bit counts as low whatever slots 8 to 10 read
// - any sample disagreeing with its bit sets noise on transfer
// - edges inside a frame, except in slots 8 to 10, realign the slot timing to the bit boundary
// - framing error, not break, preloads edge history with three highs
// - while framing error is set, completed characters are not transferred
// - sleep suppresses receive flags; hardware clears it on wakeup
// - idle-line wakeup after 10 idle bit times, 11 in nine-bit mode
// - idle count starts after start bit, or after stop when selected
// - address-mark wakeup when the character's top bit is one
// - three requests: transmit, receive, error; eight sources each enabled
// - transmit request while empty or done flag is one and enabled
// - full clears on status read then data read, plus ninth read if 9-bit
// - idle clears like full and stays clear until a new character lands
// - error flags set with full only, never on overrun
// - transmit ninth bit copied at load; received ninth bit held apart
// - parity uses top data bit; odd select makes count of ones odd
// - divisor zero stops ticks; otherwise one tick every divisor clocks
// - receiver off ignores the input pin and resets the receive logic
package asr_pkg;

	// ----------------------------------------------------------------
	// widths and slot numbers
	// ----------------------------------------------------------------
	localparam int         BAUD_DIV_W   = 13;
	localparam logic [4:0] SLOT_FIRST   = 5'h01;
	localparam logic [4:0] SLOT_LAST    = 5'h10;
	localparam logic [4:0] SLOT_CHK_A   = 5'h03;
	localparam logic [4:0] SLOT_CHK_B   = 5'h05;
	localparam logic [4:0] SLOT_CHK_C   = 5'h07;
	localparam logic [4:0] SLOT_MAJ_A   = 5'h08;
	localparam logic [4:0] SLOT_MAJ_B   = 5'h09;
	localparam logic [4:0] SLOT_MAJ_C   = 5'h0A;
	localparam logic [2:0] HIST_HIGHS   = 3'h7;
	localparam logic [2:0] HIST_CLEAR   = 3'h0;
	localparam logic [3:0] DATA_BITS_8  = 4'h8;
	localparam logic [3:0] DATA_BITS_9  = 4'h9;

	// ----------------------------------------------------------------
	// idle character length in sample ticks
	// ----------------------------------------------------------------
	localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
	localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic       RST_SLEEP      = 1'b0;
	localparam logic       RST_IDLE_ARMED = 1'b1;

	typedef enum logic [1:0] {
		ASR_HUNT  = 2'b00,
		ASR_CHECK = 2'b01,
		ASR_FRAME = 2'b10
	} asr_state_e;

	typedef struct packed {
		asr_state_e  state;
		logic [4:0]  slot;
		logic [2:0]  hist;
		logic [3:0]  bit_idx;
		logic [1:0]  samp;
		logic        frame_noise;
		logic [8:0]  shift;
		logic [7:0]  idle_cnt;
		logic        idle_armed;
		logic        sleep;
		logic        full;
		logic        ovr;
		logic        noise_flag;
		logic        framing_error_flag;
		logic        parity_error_flag;
		logic        idle;
		logic [7:0]  data;
		logic        ninth;
		logic        arm;
		logic        dseen;
		logic        nseen;
		logic        tx_irq;
		logic        rx_irq;
		logic        err_irq;
		logic        tx_ninth_sh;
	} asr_rx_s;

endpackage

/* verilog/asr_receiver.sv */
// asynchronous serial receiver with flags, wakeup and request grouping
`timescale 1ns/1ps
module asr_receiver #(
	parameter int DIV_W = asr_pkg::BAUD_DIV_W
) (
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic             serial_in_pin_in,
	input  wire logic             rx_on_in,
	input  wire logic [DIV_W-1:0] baud_divisor_value_in,
	input  wire logic             nine_bit_mode_in,
	input  wire logic             parity_on_in,
	input  wire logic             parity_odd_select_in,
	input  wire logic             wake_on_address_in,
	input  wire logic             idle_count_after_stop_in,
	input  wire logic             rx_sleep_write_in,
	input  wire logic             rx_sleep_value_in,
	input  wire logic             status_read_in,
	input  wire logic             data_read_in,
	input  wire logic             ninth_read_in,
	input  wire logic             rx_full_irq_enable_in,
	input  wire logic             idle_irq_enable_in,
	input  wire logic             overrun_irq_enable_in,
	input  wire logic             noise_irq_enable_in,
	input  wire logic             framing_irq_enable_in,
	input  wire logic             parity_irq_enable_in,
	input  wire logic             tx_empty_irq_enable_in,
	input  wire logic             tx_done_irq_enable_in,
	input  wire logic             tx_buffer_empty_flag_in,
	input  wire logic             transmit_done_flag_in,
	input  wire logic             tx_ninth_bit_in,
	input  wire logic             tx_load_in,
	output logic [7:0]            rx_data_out,
	output logic                  rx_ninth_bit_out,
	output logic                  rx_buffer_full_flag_out,
	output logic                  overrun_flag_out,
	output logic                  noise_flag_out,
	output logic                  framing_error_flag_out,
	output logic                  parity_error_flag_out,
	output logic                  idle_flag_out,
	output logic                  rx_sleep_out,
	output logic                  tx_irq_out,
	output logic                  rx_irq_out,
	output logic                  err_irq_out,
	output logic                  tx_shift_ninth_out
);
	import asr_pkg::*;

	function automatic logic maj3(input logic a, input logic b,
		input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	asr_rx_s    q;
	asr_rx_s    n;
	logic       tick_w;
	logic       s;
	logic       edge_w;
	logic [4:0] slot_n;
	logic [3:0] nbits;
	logic [7:0] idle_target;
	logic       idle_ok;
	logic       idle_hit;
	logic       bitv;
	logic       clr;
	logic       done;
	logic       xfer;
	logic       ovr_evt;
	logic       vote_fail;
	logic       fe_now;
	logic       brk;
	logic       top;
	logic       par;
	logic       awake;

	asr_baud_tick #(
		.DIV_W (DIV_W)
	) u_tick (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.enable_in  (rx_on_in),
		.divisor_in (baud_divisor_value_in),
		.tick_out   (tick_w)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		s = serial_in_pin_in;
		slot_n = (q.slot == SLOT_LAST) ? SLOT_FIRST : q.slot + 5'h01;
		edge_w = (q.hist == HIST_HIGHS) && !s;
		nbits = nine_bit_mode_in ? DATA_BITS_9 : DATA_BITS_8;
		idle_target = nine_bit_mode_in ? IDLE_TICKS_9 : IDLE_TICKS_8;
		idle_ok = 1'b0;
		idle_hit = 1'b0;
		bitv = 1'b0;
		done = 1'b0;
		xfer = 1'b0;
		ovr_evt = 1'b0;
		vote_fail = 1'b0;
		top = nine_bit_mode_in ? q.shift[8] : q.shift[7];
		par = nine_bit_mode_in ? ^q.shift : ^q.shift[7:0];
		brk = nine_bit_mode_in ? (q.shift == 9'h000)
			: (q.shift[7:0] == 8'h00);
		fe_now = 1'b0;
		awake = 1'b0;
		clr = q.arm && (q.dseen || data_read_in)
			&& (!nine_bit_mode_in || q.nseen || ninth_read_in);

		// flag clearing sequence
		if (status_read_in && (q.full || q.idle || q.ovr || q.noise_flag
			|| q.framing_error_flag || q.parity_error_flag)) begin
			n.arm = 1'b1;
		end
		if (q.arm && data_read_in) begin
			n.dseen = 1'b1;
		end
		if (q.arm && ninth_read_in) begin
			n.nseen = 1'b1;
		end
		if (clr) begin
			n.arm = 1'b0;
			n.dseen = 1'b0;
			n.nseen = 1'b0;
			n.full = 1'b0;
			n.idle = 1'b0;
			n.ovr = 1'b0;
			n.noise_flag = 1'b0;
			n.framing_error_flag = 1'b0;
			n.parity_error_flag = 1'b0;
		end

		if (!rx_on_in) begin
			n.state = ASR_HUNT;
			n.hist = HIST_CLEAR;
			n.idle_cnt = 8'h00;
		end else if (tick_w) begin
			n.hist = {q.hist[1:0], s};

			// idle line counter
			if (idle_count_after_stop_in) begin
				idle_ok = (q.state == ASR_HUNT);
			end else begin
				idle_ok = !(q.state == ASR_CHECK
					|| (q.state == ASR_FRAME && q.bit_idx == 4'h0));
			end
			if (s && idle_ok) begin
				if (q.idle_cnt != idle_target) begin
					n.idle_cnt = q.idle_cnt + 8'h01;
					idle_hit = (q.idle_cnt + 8'h01) == idle_target;
				end
			end else begin
				n.idle_cnt = 8'h00;
			end

			unique case (q.state)
				ASR_HUNT: begin
					if (edge_w) begin
						n.state = ASR_CHECK;
						n.slot = SLOT_FIRST;
						n.samp = 2'b00;
					end
				end
				ASR_CHECK: begin
					n.slot = slot_n;
					if (slot_n == SLOT_CHK_A) begin
						n.samp[0] = s;
					end
					if (slot_n == SLOT_CHK_B) begin
						n.samp[1] = s;
					end
					if (slot_n == SLOT_CHK_C) begin
						if (maj3(q.samp[0], q.samp[1], s)) begin
							n.state = ASR_HUNT;
							vote_fail = 1'b1;
						end else begin
							n.state = ASR_FRAME;
							n.bit_idx = 4'h0;
							n.frame_noise = q.samp[0] | q.samp[1] | s;
						end
					end
				end
				ASR_FRAME: begin
					if (edge_w && slot_n < SLOT_MAJ_A) begin
						n.slot = SLOT_FIRST;
					end else if (edge_w && slot_n > SLOT_MAJ_C) begin
						n.slot = SLOT_FIRST;
						n.bit_idx = q.bit_idx + 4'h1;
					end else begin
						n.slot = slot_n;
						if (slot_n == SLOT_LAST) begin
							n.bit_idx = q.bit_idx + 4'h1;
						end
						if (slot_n == SLOT_MAJ_A) begin
							n.samp[0] = s;
						end
						if (slot_n == SLOT_MAJ_B) begin
							n.samp[1] = s;
						end
						if (slot_n == SLOT_MAJ_C) begin
							bitv = maj3(q.samp[0], q.samp[1], s);
							n.frame_noise = q.frame_noise
								| (q.samp[0] != s) | (q.samp[1] != s);
							if (q.bit_idx > 4'h0 && q.bit_idx <= nbits) begin
								n.shift[q.bit_idx - 4'h1] = bitv;
							end else if (q.bit_idx == nbits + 4'h1) begin
								done = 1'b1;
							end
						end
					end
				end
				default: begin
					n.state = ASR_HUNT;
				end
			endcase

			// character complete at the stop bit
			if (done) begin
				fe_now = !bitv;
				n.state = ASR_HUNT;
				if (fe_now && brk) begin
					n.hist = HIST_CLEAR;
				end else if (fe_now) begin
					n.hist = HIST_HIGHS;
				end
				if (q.sleep && wake_on_address_in && top) begin
					n.sleep = 1'b0;
				end
				awake = !q.sleep || (wake_on_address_in && top);
				if (awake && !q.framing_error_flag) begin
					if (q.full) begin
						ovr_evt = 1'b1;
						n.ovr = 1'b1;
					end else begin
						xfer = 1'b1;
						n.full = 1'b1;
						n.data = q.shift[7:0];
						n.ninth = nine_bit_mode_in & q.shift[8];
						n.noise_flag = n.frame_noise;
						n.framing_error_flag = fe_now;
						n.parity_error_flag = parity_on_in
							&& (par != parity_odd_select_in);
						n.idle_armed = 1'b1;
						n.arm = 1'b0;
						n.dseen = 1'b0;
						n.nseen = 1'b0;
					end
				end
			end

			// idle character seen
			if (idle_hit) begin
				if (q.sleep && !wake_on_address_in) begin
					n.sleep = 1'b0;
				end else if (!q.sleep && q.idle_armed) begin
					n.idle = 1'b1;
					n.idle_armed = 1'b0;
				end
			end
		end

		if (rx_sleep_write_in) begin
			n.sleep = rx_sleep_value_in;
		end
		if (tx_load_in) begin
			n.tx_ninth_sh = tx_ninth_bit_in;
		end
		n.tx_irq = (tx_buffer_empty_flag_in && tx_empty_irq_enable_in)
			|| (transmit_done_flag_in && tx_done_irq_enable_in);
		n.rx_irq = (q.full && rx_full_irq_enable_in)
			|| (q.idle && idle_irq_enable_in);
		n.err_irq = (q.ovr && overrun_irq_enable_in)
			|| (q.noise_flag && noise_irq_enable_in)
			|| (q.framing_error_flag && framing_irq_enable_in)
			|| (q.parity_error_flag && parity_irq_enable_in);
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			q <= '0;
			q.sleep <= RST_SLEEP;
			q.idle_armed <= RST_IDLE_ARMED;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rx_data_out             = q.data;
	assign rx_ninth_bit_out        = q.ninth;
	assign rx_buffer_full_flag_out = q.full;
	assign overrun_flag_out        = q.ovr;
	assign noise_flag_out          = q.noise_flag;
	assign framing_error_flag_out  = q.framing_error_flag;
	assign parity_error_flag_out   = q.parity_error_flag;
	assign idle_flag_out           = q.idle;
	assign rx_sleep_out            = q.sleep;
	assign tx_irq_out              = q.tx_irq;
	assign rx_irq_out              = q.rx_irq;
	assign err_irq_out             = q.err_irq;
	assign tx_shift_ninth_out      = q.tx_ninth_sh;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	property p_xfer_full;
		xfer |=> q.full && q.data == $past(q.shift[7:0]);
	endproperty
	a_xfer_full: assert property (p_xfer_full)
		else $error("transfer did not fill buffer");

	property p_overrun;
		ovr_evt && !clr |=> q.ovr && q.full && $stable(q.data);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun lost buffered data");

	sequence s_edge_seen;
		rx_on_in && tick_w && q.state == ASR_HUNT
			&& q.hist == HIST_HIGHS && !serial_in_pin_in;
	endsequence

	property p_edge_check;
		s_edge_seen |=> q.state == ASR_CHECK && q.slot == SLOT_FIRST;
	endproperty
	a_edge_check: assert property (p_edge_check)
		else $error("edge not taken into start check");

	property p_vote_fail;
		vote_fail |=> q.state == ASR_HUNT && q.hist[0] == $past(s);
	endproperty
	a_vote_fail: assert property (p_vote_fail)
		else $error("rejected start did not return to hunt");

	property p_fe_blocks;
		$rose(q.full) |-> !$past(q.framing_error_flag);
	endproperty
	a_fe_blocks: assert property (p_fe_blocks)
		else $error("transfer while framing error set");

	property p_sleep_quiet;
		q.sleep && !wake_on_address_in |=> !$rose(q.full) && !$rose(q.idle);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("flag set while asleep");

	property p_err_with_full;
		$rose(q.noise_flag) || $rose(q.framing_error_flag)
			|| $rose(q.parity_error_flag) |-> $rose(q.full);
	endproperty
	a_err_with_full: assert property (p_err_with_full)
		else $error("error flag set without new character");

	property p_fe_preload;
		done && fe_now && !brk && rx_on_in |=> q.hist == HIST_HIGHS;
	endproperty
	a_fe_preload: assert property (p_fe_preload)
		else $error("edge history not preloaded");

	property p_tx_irq;
		tx_buffer_empty_flag_in && tx_empty_irq_enable_in |=> q.tx_irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("transmit request missing");

endmodule
